// ### sleep_subtract_execute.sv
// Execute stage for the power-down and subtract-w-from-file ops.
// Assumes fetch presents one instruction per valid cycle, and the
// register file returns the addressed byte combinationally.
// Flags and working register live here; the status register and the
// watchdog outside only ever see the registered copies.
// Limitations: the oscillator is not gated here; oscStop only asks the
// clock source to stop, and the wake path costs two cycles of latency
// through its synchroniser. Only one instruction is taken per cycle, and
// fileRdData matters only while a subtract is presented.
// Other opcodes are accepted but leave the flags, working register and file write untouched.
// The clock must keep running while asleep for the wake path to work.
//
// Notes on behaviour
// - Power-down op clears the power-down flag.
// - Power-down op sets the timeout flag.
// - Power-down op clears watchdog counter and prescaler.
// - Then core sleeps with oscillator stopped; one program word.
// - Subtract computes file minus working, 8-bit two's complement.
// - Destination bit 0 writes result to working register only.
// - Destination bit 1 writes result back to file register.
// - Negative result clears carry; result wraps modulo 256.
// - Zero result sets carry and zero; positive sets carry, clears zero.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module sleep_subtract_execute
  import sse_pkg::*;
(
  sys_clk,
  rst_n,
  instrValid,
  instrWord,
  fileRdData,
  wakeEvent,
  fileAddr,
  fileWrData,
  fileWrEn,
  wReg,
  carryFlag,
  digitCarryFlag,
  zeroFlag,
  timeoutFlag,
  powerdownFlag,
  watchdogClear,
  prescalerClear,
  oscStop,
  sleepState,
  instrAccept
);
  // Clock, reset, fetch and wake inputs
  input  wire logic        sys_clk;
  input  wire logic        rst_n;
  input  wire logic        instrValid;
  input  wire logic [13:0] instrWord;
  input  wire logic [7:0]  fileRdData;
  input  wire logic        wakeEvent;

  // Register file write side
  output logic      [6:0]  fileAddr;
  output logic      [7:0]  fileWrData;
  output logic             fileWrEn;

  // Working register and status flags
  output logic      [7:0]  wReg;
  output logic             carryFlag;
  output logic             digitCarryFlag;
  output logic             zeroFlag;
  output logic             timeoutFlag;
  output logic             powerdownFlag;

  // Watchdog and power control
  output logic             watchdogClear;
  output logic             prescalerClear;
  output logic             oscStop;
  output logic             sleepState;
  output logic             instrAccept;

  // ==========================================================
  // Registered state; status flags are separate bits here and are
  // packed into the status register outside
  sse_state_t  state_r,    state_nxt;
  logic [7:0]  w_r,        w_nxt;
  logic        c_r,        c_nxt;
  logic        dc_r,       dc_nxt;
  logic        z_r,        z_nxt;
  logic        to_r,       to_nxt;
  logic        pd_r,       pd_nxt;
  logic [6:0]  addr_r,     addr_nxt;
  logic [7:0]  wdata_r,    wdata_nxt;
  logic        wen_r,      wen_nxt;
  logic        wdClr_r,    wdClr_nxt;
  logic        psClr_r,    psClr_nxt;
  logic        acc_r,      acc_nxt;
  logic        asleep_r,   asleep_nxt;
  // Only wake2_r may be read; wake1_r can be metastable
  logic        wake1_r,    wake2_r;

  // Decoded instruction
  logic        isSleep;
  logic        isSub;
  logic        destFile;
  logic        canIssue;

  // Subtractor results; carry and digit carry mean no borrow
  logic [7:0]  subDiff;
  logic        subCarry;
  logic        subDigit;
  logic        subZero;

  // ==========================================================
  // Decode; sleep blocks issue until a wake event
  // Unknown opcodes fall through both decodes: accepted, flags, W and file write untouched.
  // destFile is left unqualified since it is only read under isSub.
  // Sleep and subtract never overlap, their encodings differ in bit 9.
  assign canIssue = instrValid && (state_r == SSE_RUN);
  assign isSleep  = canIssue && (instrWord == SSE_OP_SLEEP);
  assign isSub    = canIssue &&
                    ((instrWord & SSE_SUB_MASK) == SSE_SUB_PATTERN);
  assign destFile = instrWord[SSE_DEST_BIT];

  // ==========================================================
  // Arithmetic unit
  // Kept combinational so a subtract completes in a single cycle;
  // the price is a long path from fileRdData through the adder
  // file minus working
  sse_sub8 u_sub
  (
    .fileVal    (fileRdData),
    .wVal       (w_r),
    .diff       (subDiff),
    .carryOut   (subCarry),
    .digitCarry (subDigit),
    .zeroOut    (subZero)
  );

  // ==========================================================
  // Wake input crosses from outside; two flops before use
  // Costs two cycles of wake latency against metastability risk
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wake1_r <= 1'b0;
      wake2_r <= 1'b0;
    end
    else
    begin
      wake1_r <= wakeEvent;
      wake2_r <= wake1_r;
    end
  end

  // ==========================================================
  // Next-state logic for execute results
  // Everything but the address and accept defaults to hold and pulses to low, so an opcode that
  // is not decoded cannot disturb the flags or the working register.
  always_comb
  begin
    state_nxt = state_r;
    w_nxt     = w_r;
    c_nxt     = c_r;
    dc_nxt    = dc_r;
    z_nxt     = z_r;
    to_nxt    = to_r;
    pd_nxt    = pd_r;
    addr_nxt  = instrWord[6:0]; // Address follows operand field
    wdata_nxt = wdata_r;
    wen_nxt   = 1'b0;
    wdClr_nxt = 1'b0;
    psClr_nxt = 1'b0;
    acc_nxt   = canIssue;
    case (state_r)
      SSE_RUN:
      begin
        // Flags, clears and sleep all land on the same edge
        if (isSleep)
        begin
          pd_nxt    = 1'b0;
          to_nxt    = 1'b1;
          wdClr_nxt = 1'b1;
          psClr_nxt = 1'b1;
          state_nxt = SSE_ASLEEP;
        end
        else if (isSub)
        begin
          // Flags update whatever the destination
          // carry clear on borrow, wraps
          c_nxt  = subCarry;
          z_nxt  = subZero;
          dc_nxt = subDigit;
          if (destFile)
          begin
            wdata_nxt = subDiff;
            wen_nxt   = 1'b1;
          end
          else
          begin
            w_nxt = subDiff;
          end
        end
      end
      SSE_ASLEEP:
      begin
        // Oscillator restart is outside this block; wake just resumes
        // Instructions offered while asleep are dropped, not queued
        if (wake2_r)
        begin
          state_nxt = SSE_RUN;
        end
      end
      default:
      begin
        state_nxt = SSE_RUN;
      end
    endcase
  end

  // ==========================================================
  // Register stage; flags keep last value across sleep
  // Synchronous reset only, so a reset also needs a running clock
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= SSE_RUN;
      w_r     <= SSE_W_RST;
      c_r     <= SSE_FLAG_RST;
      dc_r    <= SSE_FLAG_RST;
      z_r     <= SSE_FLAG_RST;
      to_r    <= SSE_TIMEOUT_RST;
      pd_r    <= SSE_PWRDN_RST;
      addr_r  <= SSE_ADDR_RST;
      wdata_r <= SSE_WDATA_RST;
      wen_r   <= 1'b0;
      wdClr_r <= 1'b0;
      psClr_r <= 1'b0;
      acc_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      w_r     <= w_nxt;
      c_r     <= c_nxt;
      dc_r    <= dc_nxt;
      z_r     <= z_nxt;
      to_r    <= to_nxt;
      pd_r    <= pd_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      wen_r   <= wen_nxt;
      wdClr_r <= wdClr_nxt;
      psClr_r <= psClr_nxt;
      acc_r   <= acc_nxt;
    end
  end

  // ==========================================================
  // Sleep indication in a flop of its own, so oscStop and
  // sleepState leave the block with no decode behind them
  // asleep follows state
  always_comb
  begin
    asleep_nxt = (state_nxt == SSE_ASLEEP);
  end

  // Follows the state register edge for edge; the reset value
  // matches the run state so no false sleep follows reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      asleep_r <= SSE_ASLEEP_RST;
    end
    else
    begin
      asleep_r <= asleep_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  // No decode on any port, so downstream timing sees clean edges
  assign fileAddr       = addr_r;
  assign fileWrData     = wdata_r;
  assign fileWrEn       = wen_r;
  assign wReg           = w_r;
  assign carryFlag      = c_r;
  assign digitCarryFlag = dc_r;
  assign zeroFlag       = z_r;
  assign timeoutFlag    = to_r;
  assign powerdownFlag  = pd_r;
  assign watchdogClear  = wdClr_r;
  assign prescalerClear = psClr_r;
  assign oscStop        = asleep_r;
  assign sleepState     = asleep_r;
  assign instrAccept    = acc_r;
endmodule : sleep_subtract_execute

// ### sleep_subtract_execute_assertions.sv
// Checker of execute-stage results, watching only top-level ports.
// Assumes it is bound onto sleep_subtract_execute below.
`timescale 1ns/1ps
module sse_exec_checker
  import sse_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        instrValid,
  input wire logic [13:0] instrWord,
  input wire logic [7:0]  fileRdData,
  input wire logic [7:0]  fileWrData,
  input wire logic        fileWrEn,
  input wire logic [7:0]  wReg,
  input wire logic        carryFlag,
  input wire logic        digitCarryFlag,
  input wire logic        zeroFlag,
  input wire logic        timeoutFlag,
  input wire logic        powerdownFlag,
  input wire logic        watchdogClear,
  input wire logic        prescalerClear,
  input wire logic        oscStop,
  input wire logic        sleepState
);
  // ==========================================================
  // Decode of what the core should take this cycle
  wire       taken   = instrValid && !sleepState;
  wire       isSleep = taken && (instrWord == SSE_OP_SLEEP);
  wire       isSub   = taken &&
                       ((instrWord & SSE_SUB_MASK) == SSE_SUB_PATTERN);
  wire       dBit    = instrWord[SSE_DEST_BIT];
  wire [8:0] diff9   = {1'b0, fileRdData} - {1'b0, wReg};
  wire [7:0] diff8   = diff9[7:0];
  wire       borrow  = diff9[8];
  wire       lowOk   = fileRdData[3:0] >= wReg[3:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sleepTaken; isSleep; endsequence
  sequence clearPulse; watchdogClear && prescalerClear ##1 !watchdogClear;
  endsequence
  // ==========================================================
  // Power-down op, then subtract results one cycle later
  a_pd_clear: assert property (sleepTaken |=> !powerdownFlag)
    else $error("power-down flag not cleared");
  a_to_set: assert property (sleepTaken |=> timeoutFlag)
    else $error("timeout flag not set");
  a_wdog_pulse: assert property (sleepTaken |=> clearPulse)
    else $error("watchdog clear pulse wrong");
  a_sleep_enter: assert property (sleepTaken |=> sleepState && oscStop)
    else $error("sleep not entered");
  a_sub_to_w: assert property (isSub && !dBit |=>
    wReg == $past(diff8) && !fileWrEn) else $error("sub to w wrong");
  a_sub_to_file: assert property (isSub && dBit |=>
    fileWrEn && fileWrData == $past(diff8) && $stable(wReg))
    else $error("sub to file wrong");
  a_sub_carry: assert property (isSub |=> carryFlag == !$past(borrow))
    else $error("carry wrong");
  a_sub_zero: assert property (isSub |=> zeroFlag == ($past(diff8) == 0))
    else $error("zero wrong");
  a_sub_dc: assert property (isSub |=> digitCarryFlag == $past(lowOk))
    else $error("digit carry wrong");
endmodule : sse_exec_checker

bind sleep_subtract_execute sse_exec_checker u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
  .instrWord(instrWord), .fileRdData(fileRdData), .wReg(wReg),
  .fileWrData(fileWrData), .fileWrEn(fileWrEn), .carryFlag(carryFlag),
  .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag),
  .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
  .watchdogClear(watchdogClear), .prescalerClear(prescalerClear),
  .oscStop(oscStop), .sleepState(sleepState));

// ### sleep_subtract_execute_tb.sv
// Self-checking bench for the execute stage; table of subtract cases.
// Assumes the bench alone drives every port of the block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); \
  end end
module sleep_subtract_execute_tb;
  import sse_pkg::*;
  logic        sys_clk = 0, rst_n = 0, instrValid = 0, wakeEvent = 0;
  logic [13:0] instrWord = 14'h0000;
  logic [7:0]  fileRdData = 8'h00, fileWrData, wReg;
  logic [6:0]  fileAddr;
  logic        fileWrEn, carryFlag, digitCarryFlag, zeroFlag, timeoutFlag;
  logic        powerdownFlag, watchdogClear, prescalerClear, oscStop;
  logic        sleepState, instrAccept;
  logic [41:0] rows [9];
  logic [41:0] r;
  int          n_errors = 0, check_count = 0, cycles = 0, i;
  // ==========================================================
  // Clock, hang guard, device
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  sleep_subtract_execute dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .instrValid(instrValid), .instrWord(instrWord), .fileAddr(fileAddr),
    .fileRdData(fileRdData), .wakeEvent(wakeEvent), .wReg(wReg),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn), .carryFlag(carryFlag),
    .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag),
    .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
    .watchdogClear(watchdogClear), .prescalerClear(prescalerClear),
    .oscStop(oscStop), .sleepState(sleepState),
    .instrAccept(instrAccept));
  // Reset held 12 cycles, then reset values checked
  task do_reset;
    rst_n <= 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1;
    #1;
    `CHK("w", 8'h00, wReg)
    `CHK("flags", 3'b000, {carryFlag, digitCarryFlag, zeroFlag})
    `CHK("to pd", 2'b11, {timeoutFlag, powerdownFlag})
    `CHK("sleep", 1'b0, sleepState)
    $display("reset test done");
  endtask : do_reset
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Rows: word, file byte, w, write enable, write byte, C DC Z
  initial
  begin
    rows = '{{14'h0205, 8'h02, 8'h02, 1'b0, 8'h00, 3'b110},
      {14'h0285, 8'h03, 8'h02, 1'b1, 8'h01, 3'b110},
      {14'h0285, 8'h02, 8'h02, 1'b1, 8'h00, 3'b111},
      {14'h0285, 8'h01, 8'h02, 1'b1, 8'hff, 3'b000},
      {14'h0e85, 8'h77, 8'h02, 1'b0, 8'h00, 3'b000},
      {14'h0205, 8'h12, 8'h10, 1'b0, 8'h00, 3'b110},
      {14'h02ff, 8'h05, 8'h10, 1'b1, 8'hf5, 3'b010},
      {14'h0200, 8'h11, 8'h01, 1'b0, 8'h00, 3'b110},
      {14'h0285, 8'h20, 8'h01, 1'b1, 8'h1f, 3'b100}};
    do_reset();
    // Back to back: row i driven while row i-1 is checked
    for (i = 0; i <= 9; i++)
    begin
      @(posedge sys_clk);
      instrValid <= (i < 9);
      if (i < 9) {instrWord, fileRdData} <= rows[i][41:20];
      #1;
      if (i > 0)
      begin
        r = rows[i-1];
        `CHK("w", r[19:12], wReg)
        `CHK("wrEn", r[11], fileWrEn)
        if (r[11]) `CHK("wrData", r[10:3], fileWrData)
        `CHK("carry", r[2], carryFlag)
        `CHK("zero", r[0], zeroFlag)
        `CHK("dc", r[1], digitCarryFlag)
        `CHK("addr", r[34:28], fileAddr)
        `CHK("accept", 1'b1, instrAccept)
      end
    end
    $display("subtract table done");
    // Sleep, a refused subtract while asleep, then wake
    @(posedge sys_clk);
    instrWord <= SSE_OP_SLEEP;
    instrValid <= 1;
    @(posedge sys_clk);
    {instrWord, fileRdData} <= {14'h0205, 8'h55};
    #1;
    `CHK("sleep accept", 1'b1, instrAccept)
    `CHK("pd", 1'b0, powerdownFlag)
    `CHK("to", 1'b1, timeoutFlag)
    `CHK("clr", 2'b11, {watchdogClear, prescalerClear})
    `CHK("asleep", 2'b11, {sleepState, oscStop})
    @(posedge sys_clk);
    instrValid <= 0;
    #1;
    `CHK("clr end", 2'b00, {watchdogClear, prescalerClear})
    `CHK("w kept", 8'h01, wReg)
    `CHK("accept", 1'b0, instrAccept)
    @(posedge sys_clk);
    wakeEvent <= 1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("still asleep", 1'b1, sleepState)
    @(posedge sys_clk);
    wakeEvent <= 0;
    #1;
    `CHK("awake", 1'b0, sleepState)
    `CHK("osc run", 1'b0, oscStop)
    $display("sleep test done");
    @(posedge sys_clk);
    do_reset();
    print_verdict();
  end
endmodule : sleep_subtract_execute_tb

// ### sse_pkg.sv
// Constants for the power-down and subtract execute block.
// Assumes a 14-bit instruction word and 8-bit data path.
package sse_pkg;
  // ==========================================================
  // Instruction encodings
  localparam logic [13:0] SSE_OP_SLEEP     = 14'h0063;
  localparam logic [13:0] SSE_SUB_MASK     = 14'h3f00;
  localparam logic [13:0] SSE_SUB_PATTERN  = 14'h0200;
  localparam int          SSE_DEST_BIT     = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  SSE_W_RST        = 8'h00;
  localparam logic        SSE_TIMEOUT_RST  = 1'b1;
  localparam logic        SSE_PWRDN_RST    = 1'b1;
  localparam logic        SSE_FLAG_RST     = 1'b0;
  localparam logic [7:0]  SSE_WDOG_CLEAR   = 8'h00;
  localparam logic [7:0]  SSE_PRESC_CLEAR  = 8'h00;
  localparam logic [6:0]  SSE_ADDR_RST     = 7'h00;
  localparam logic [7:0]  SSE_WDATA_RST    = 8'h00;
  localparam logic        SSE_ASLEEP_RST   = 1'b0;
  // ==========================================================
  // Execute FSM states
  typedef enum logic [1:0] {SSE_RUN, SSE_ASLEEP} sse_state_t;
endpackage : sse_pkg

// ### sse_sub8.sv
// 8-bit file-minus-working subtractor with borrow flags.
// Assumes purely combinational use by the execute stage.
`timescale 1ns/1ps
module sse_sub8
  import sse_pkg::*;
(
  fileVal,
  wVal,
  diff,
  carryOut,
  digitCarry,
  zeroOut
);
  input  wire logic [7:0] fileVal;
  input  wire logic [7:0] wVal;
  output logic      [7:0] diff;
  output logic            carryOut;
  output logic            digitCarry;
  output logic            zeroOut;

  logic [8:0] full;
  logic [4:0] low;

  // ==========================================================
  // Two's complement: f + ~w + 1; carry means no borrow
  always_comb
  begin
    full       = {1'b0, fileVal} + {1'b0, ~wVal} + 9'h001;
    low        = {1'b0, fileVal[3:0]} + {1'b0, ~wVal[3:0]} + 5'h01;
    diff       = full[7:0];
    carryOut   = full[8];
    digitCarry = low[4];
    zeroOut    = (full[7:0] == 8'h00);
  end
endmodule : sse_sub8
